// ===== core/ccs_control_status.v
// CAN controller control/status register, node state and bus stop logic
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"

module ccs_control_status #(
  parameter ADDR_W = 16,
  parameter ECNT_W = 9
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire rmw_read,
  input wire eng_tx_msg,
  input wire eng_bus_msg,
  input wire eng_err_frame,
  input wire eng_tx_busy,
  input wire eng_store_busy,
  input wire [ECNT_W-1:0] tx_err_cnt,
  input wire [ECNT_W-1:0] rx_err_cnt,
  input wire bit_tick,
  input wire can_rx,
  input wire eng_tx_bit,
  input wire port_out,
  output reg pin_out,
  output reg bus_enable,
  output reg err_cnt_clear,
  output wire node_change_irq
);

  // ****************************************
  // State codes for the bus stop sequencer
  // ****************************************
  localparam ST_RUN = 2'b00;
  localparam ST_PEND = 2'b01;
  localparam ST_HALT = 2'b10;
  localparam ST_RECOV = 2'b11;

  // ****************************************
  // Declarations
  // ****************************************
  reg [1:0] state_reg, state_next, node_state_reg, node_state_next;
  reg halt_reg, busoff_stop_reg, busoff_stop_next, busoff_latch_reg, flag_set;
  reg tx_pin_route_en, node_change_irq_en, node_change_flag, tx_active, rx_active;
  reg rx_meta_reg, rx_sync_reg, ack_reg;
  reg [15:0] csr_view;
  reg [7:0] seq_target;
  wire req, hit_csr, wr_ok, wr_lo, wr_hi, halt_wr1, halt_wr0;
  wire recov_done, busoff_enter, busoff_exit;

  // ****************************************
  // Avalon-MM slave handshake
  // ****************************************

  // One wait cycle per access so read data comes from a flop
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign hit_csr = (avs_address == `CCS_CSR_ADDR);
  assign wr_ok = avs_write & ack_reg & hit_csr;
  assign wr_lo = wr_ok & avs_byteenable[`CCS_LANE_LO];
  assign wr_hi = wr_ok & avs_byteenable[`CCS_LANE_HI];
  assign halt_wr1 = wr_lo & avs_writedata[`CCS_HALT_BIT];
  assign halt_wr0 = wr_lo & ~avs_writedata[`CCS_HALT_BIT];

  // Ack pulses for one cycle after a request is seen
  always @(posedge core_clk)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  // ****************************************
  // Receive pin synchroniser
  // ****************************************

  // Pin is asynchronous; only the second stage is used
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= can_rx;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // ****************************************
  // Activity status
  // ****************************************

  // Error and overload frames mask both activity bits
  always @*
  begin
    tx_active = eng_tx_msg & ~eng_err_frame;
    rx_active = eng_bus_msg & ~eng_err_frame & ~halt_reg;
    if (halt_reg)
      rx_active = 1'b0;
  end

  // ****************************************
  // Node state
  // ****************************************

  // Bus off holds until recovery ends; the clear pulse masks the stale count
  assign busoff_enter = (tx_err_cnt > `CCS_BUSOFF_LIMIT) & ~busoff_latch_reg & ~err_cnt_clear;
  assign busoff_exit = busoff_latch_reg & recov_done & (state_reg == ST_RECOV);

  always @*
  begin
    if (busoff_latch_reg || busoff_enter)
      node_state_next = `CCS_NS_BUSOFF;
    else if (tx_err_cnt > `CCS_PASSIVE_LIMIT || rx_err_cnt > `CCS_PASSIVE_LIMIT)
      node_state_next = `CCS_NS_PASSIVE;
    else if (tx_err_cnt > `CCS_WARN_LIMIT || rx_err_cnt > `CCS_WARN_LIMIT)
      node_state_next = `CCS_NS_WARN;
    else
      node_state_next = `CCS_NS_ACTIVE;
    if (busoff_exit || err_cnt_clear)
      node_state_next = `CCS_NS_ACTIVE;
  end

  // Counters may lag one cycle after clear; force active at exit
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      node_state_reg <= `CCS_NS_ACTIVE;
      busoff_latch_reg <= 1'b0;
    end
    else
    begin
      node_state_reg <= node_state_next;
      if (busoff_enter)
        busoff_latch_reg <= 1'b1;
      else if (busoff_exit)
        busoff_latch_reg <= 1'b0;
    end
  end

  // Only the four upward steps of the ring raise the flag
  always @*
  begin
    flag_set = 1'b0;
    case ({node_state_reg, node_state_next})
      {`CCS_NS_ACTIVE, `CCS_NS_WARN}: flag_set = 1'b1;
      {`CCS_NS_WARN, `CCS_NS_PASSIVE}: flag_set = 1'b1;
      {`CCS_NS_PASSIVE, `CCS_NS_BUSOFF}: flag_set = 1'b1;
      {`CCS_NS_BUSOFF, `CCS_NS_ACTIVE}: flag_set = 1'b1;
      default: flag_set = 1'b0;
    endcase
  end

  // ****************************************
  // Control bits and change flag
  // ****************************************

  // A set in the same cycle as a clear wins
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tx_pin_route_en <= `CCS_TOE_RST;
      node_change_irq_en <= `CCS_NIE_RST;
      node_change_flag <= 1'b0;
    end
    else
    begin
      if (wr_lo)
      begin
        tx_pin_route_en <= avs_writedata[`CCS_TOE_BIT];
        node_change_irq_en <= avs_writedata[`CCS_NIE_BIT];
      end
      if (flag_set)
        node_change_flag <= 1'b1;
      else if (wr_hi && !avs_writedata[`CCS_NT_BIT])
        node_change_flag <= 1'b0;
    end
  end

  // Level request, drops as soon as flag or enable clears
  assign node_change_irq = node_change_flag & node_change_irq_en;

  // ****************************************
  // Bus stop sequencer
  // ****************************************

  // Deferral covers transmission and buffer storage only
  always @*
  begin
    state_next = state_reg;
    busoff_stop_next = busoff_stop_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (busoff_enter)
        begin
          state_next = ST_HALT;
          busoff_stop_next = 1'b1;
        end
        else if (halt_wr1)
        begin
          if (eng_tx_busy || eng_store_busy)
            state_next = ST_PEND;
          else
            state_next = ST_HALT;
          busoff_stop_next = 1'b0;
        end
      end
      ST_PEND:
      begin
        if (busoff_enter)
        begin
          state_next = ST_HALT;
          busoff_stop_next = 1'b1;
        end
        else if (!eng_tx_busy && !eng_store_busy)
          state_next = ST_HALT;
      end
      ST_HALT:
      begin
        if (halt_wr0)
          state_next = ST_RECOV;
      end
      ST_RECOV:
      begin
        if (halt_wr1)
          state_next = ST_HALT;
        else if (recov_done)
        begin
          state_next = ST_RUN;
          busoff_stop_next = 1'b0;
        end
      end
      default: state_next = ST_HALT;
    endcase
  end

  // Reset leaves the bus stopped; counters are untouched here
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_HALT;
      busoff_stop_reg <= 1'b0;
      err_cnt_clear <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busoff_stop_reg <= busoff_stop_next;
      err_cnt_clear <= busoff_exit;
    end
  end

  // Stop bit shows 1 in both halted and recovering states
  always @*
  begin
    halt_reg = (state_reg == ST_HALT) || (state_reg == ST_RECOV);
    seq_target = busoff_stop_reg ? `CCS_SEQ_BUSOFF : `CCS_SEQ_RESTART;
  end

  // ****************************************
  // Recessive sequence detector
  // ****************************************
  ccs_recessive_counter #(
    .RUN_BITS(`CCS_SEQ_BITS),
    .CNT_W(8)
  ) u_recessive (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run_en(state_reg == ST_RECOV),
    .bit_tick(bit_tick),
    .rx_level(rx_sync_reg),
    .target(seq_target),
    .done_reg(recov_done)
  );

  // ****************************************
  // Pin routing and engine enable
  // ****************************************

  // Stopped controller drives recessive high on its output when routing is on; with routing off the pin follows the port
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pin_out <= 1'b1;
      bus_enable <= 1'b0;
    end
    else
    begin
      bus_enable <= ~halt_reg;
      if (!tx_pin_route_en)
        pin_out <= port_out;
      else if (halt_reg)
        pin_out <= 1'b1;
      else
        pin_out <= eng_tx_bit;
    end
  end

  // ****************************************
  // Read data
  // ****************************************

  // Reserved bit 1 has no storage, ignores writes and reads as zero
  always @*
  begin
    csr_view = 16'h0000;
    csr_view[`CCS_TXA_BIT] = tx_active;
    csr_view[`CCS_RXA_BIT] = rx_active;
    csr_view[`CCS_NT_BIT] = node_change_flag | rmw_read;
    csr_view[`CCS_NS_HI_BIT] = node_state_reg[1];
    csr_view[`CCS_NS_LO_BIT] = node_state_reg[0];
    csr_view[`CCS_TOE_BIT] = tx_pin_route_en;
    csr_view[`CCS_NIE_BIT] = node_change_irq_en;
    csr_view[`CCS_HALT_BIT] = halt_reg;
  end

  // Unmapped addresses read zero and ignore writes
  always @(posedge core_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_reg)
    begin
      if (hit_csr)
        avs_readdata <= {16'h0000, csr_view};
      else
        avs_readdata <= 32'h00000000;
    end
  end

endmodule // ccs_control_status
`default_nettype wire

// ===== core/ccs_defines.vh
// Constants for the CAN control/status block
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
// Register map (byte address)
`define CCS_CSR_ADDR 16'h1C00
// Low byte fields
`define CCS_HALT_BIT 0
`define CCS_RSV_BIT 1
`define CCS_NIE_BIT 2
`define CCS_TOE_BIT 7
// High byte fields
`define CCS_NS_LO_BIT 8
`define CCS_NS_HI_BIT 9
`define CCS_NT_BIT 10
`define CCS_RXA_BIT 14
`define CCS_TXA_BIT 15
// Byte lanes
`define CCS_LANE_LO 0
`define CCS_LANE_HI 1
// Node states
`define CCS_NS_ACTIVE 2'h0
`define CCS_NS_WARN 2'h1
`define CCS_NS_PASSIVE 2'h2
`define CCS_NS_BUSOFF 2'h3
// Error counter thresholds
`define CCS_WARN_LIMIT 9'h060
`define CCS_PASSIVE_LIMIT 9'h07F
`define CCS_BUSOFF_LIMIT 9'h0FF
// Recessive sequence figures
`define CCS_SEQ_BITS 11
`define CCS_SEQ_RESTART 8'h01
`define CCS_SEQ_BUSOFF 8'h80
// Reset values
`define CCS_HALT_RST 1'b1
`define CCS_TOE_RST 1'b0
`define CCS_NIE_RST 1'b0
`endif

// ===== core/ccs_recessive_counter.v
// Counts runs of consecutive recessive bits on the receive input
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"

module ccs_recessive_counter #(
  parameter RUN_BITS = `CCS_SEQ_BITS,
  parameter CNT_W = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire run_en,
  input wire bit_tick,
  input wire rx_level,
  input wire [CNT_W-1:0] target,
  output reg done_reg
);

  // ****************************************
  // Bit and sequence counters
  // ****************************************
  reg [4:0] bit_cnt_reg;
  reg [CNT_W-1:0] seq_cnt_reg;
  wire run_full;

  assign run_full = (bit_cnt_reg == RUN_BITS[4:0] - 5'h01);

  // A dominant bit restarts the run; counting stops once done
  always @(posedge core_clk)
  begin
    if (sys_rst || !run_en)
    begin
      bit_cnt_reg <= 5'h00;
      seq_cnt_reg <= {CNT_W{1'b0}};
      done_reg <= 1'b0;
    end
    else if (bit_tick && !done_reg)
    begin
      if (!rx_level)
        bit_cnt_reg <= 5'h00;
      else if (run_full)
      begin
        bit_cnt_reg <= 5'h00;
        seq_cnt_reg <= seq_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        if (seq_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1} == target)
          done_reg <= 1'b1;
      end
      else
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

endmodule // ccs_recessive_counter
`default_nettype wire

// ===== tb/ccs_can_bus_model.sv
// Behavioural CAN bus behind a transceiver for the control/status bench
`timescale 1ns/100ps
`default_nettype none

module ccs_can_bus_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic dominant,
  output logic bit_tick,
  output logic can_rx
);
  logic div_reg;
  // Two clocks a bit keeps the 128-run recovery short
  always @(posedge core_clk)
  begin
    if (sys_rst)
      div_reg <= 1'b0;
    else
      div_reg <= ~div_reg;
  end
  assign bit_tick = div_reg;
  // Bus pull makes an undriven line recessive
  assign can_rx = ~dominant;
endmodule // ccs_can_bus_model

`default_nettype wire

// ===== tb/ccs_control_status_assertions.sv
// Port checks for the CAN control/status block
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"

module ccs_control_status_assertions #(
  parameter ADDR_W = 16,
  parameter ECNT_W = 9
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [ECNT_W-1:0] tx_err_cnt,
  input wire logic port_out,
  input wire logic pin_out,
  input wire logic bus_enable,
  input wire logic err_cnt_clear,
  input wire logic node_change_irq
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // One wait state, then the answer
  sequence one_wait_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // Halted over two cycles, with the port idle high in the first of them
  sequence halted_s;
    (!bus_enable && port_out) ##1 !bus_enable;
  endsequence
  wire rd_done = avs_read && !avs_waitrequest;
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> one_wait_s)
    else $error("bus answer not after one wait state");
  unmapped_zero_a: assert property (rd_done && avs_address != `CCS_CSR_ADDR |->
    avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  rx_halt_a: assert property (rd_done && !bus_enable |-> !avs_readdata[14])
    else $error("receive activity while stopped");
  tx_idle_a: assert property (halted_s |-> pin_out)
    else $error("transmit pin not recessive while stopped");
  irq_hold_a: assert property (node_change_irq && !avs_write |=> node_change_irq)
    else $error("interrupt level dropped without a write");
  busoff_stop_a: assert property ($rose(tx_err_cnt > `CCS_BUSOFF_LIMIT) |-> ##2 !bus_enable)
    else $error("bus off did not stop the bus");
  clr_pulse_a: assert property (err_cnt_clear |=> !err_cnt_clear && bus_enable)
    else $error("counter clear not a pulse at resume");
  clr_busoff_a: assert property (err_cnt_clear |-> tx_err_cnt > `CCS_BUSOFF_LIMIT)
    else $error("counter clear outside bus off recovery");
endmodule // ccs_control_status_assertions

bind ccs_control_status ccs_control_status_assertions #(.ADDR_W(ADDR_W), .ECNT_W(ECNT_W))
  u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tx_err_cnt(tx_err_cnt), .port_out(port_out),
  .pin_out(pin_out), .bus_enable(bus_enable), .err_cnt_clear(err_cnt_clear),
  .node_change_irq(node_change_irq));

`default_nettype wire

// ===== tb/ccs_control_status_tb.sv
// Self-checking bench for the CAN control/status block
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defines.vh"

module ccs_control_status_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] adr = 16'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] be = 4'h0;
  logic rmw = 1'b0;
  logic txm = 1'b0;
  logic busm = 1'b0;
  logic errf = 1'b0;
  logic txb = 1'b0;
  logic stb = 1'b0;
  logic [8:0] tec = 9'h000;
  logic [8:0] rec = 9'h000;
  logic txbit = 1'b0;
  logic port = 1'b1;
  logic dom = 1'b0;
  logic [15:0] q;
  int fail_count = 0;
  int cmp_count = 0;
  wire [31:0] rdata;
  wire wrq, tick, rx, pin, ben, clr, irq;
  localparam logic [15:0] CAN_CONTROL_AND_STATUS = `CCS_CSR_ADDR;

  ccs_control_status u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wrq), .rmw_read(rmw), .eng_tx_msg(txm),
    .eng_bus_msg(busm), .eng_err_frame(errf), .eng_tx_busy(txb), .eng_store_busy(stb),
    .tx_err_cnt(tec), .rx_err_cnt(rec), .bit_tick(tick), .can_rx(rx),
    .eng_tx_bit(txbit), .port_out(port), .pin_out(pin), .bus_enable(ben),
    .err_cnt_clear(clr), .node_change_irq(irq));
  ccs_can_bus_model u_bus (.core_clk(core_clk), .sys_rst(sys_rst), .dominant(dom),
    .bit_tick(tick), .can_rx(rx));

  // ****
  // Helpers
  // ****
  always #50 core_clk = ~core_clk;
  // Error counters live outside the block; its clear pulse zeroes them
  always @(posedge core_clk)
  begin
    if (clr === 1'b1)
    begin
      tec <= 9'h000;
      rec <= 9'h000;
    end
  end
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One Avalon access; two idle edges first let slow status settle
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
    input logic [3:0] b);
    repeat (2) @(posedge core_clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    // Caller's byte enables pick the lanes; callers keep reserved bit 1 at zero
    wd <= {16'h0000, d};
    be <= b;
    // No timeout here; only the watchdog ends a wait for an answer that never comes
    do
      @(posedge core_clk);
    while (wrq !== 1'b0);
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Poll the stop bit until it shows the wanted value
  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    do
    begin
      acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
      n++;
    end
    while (q[0] !== v && n < 2000);
    check("halt", {15'h0000, q[0]}, {15'h0000, v});
  endtask
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run
  initial
  begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    complete_run();
  end

  // ****
  // Tests
  // ****
  initial
  begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("csr_rst", q, 16'h0001);
    acc(1'b0, 16'h1C04, 16'h0000, 4'h3);
    check("unmapped", q, 16'h0000);
    dom <= 1'b1;
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    repeat (40) @(posedge core_clk);
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("no_run", q, 16'h0001);
    dom <= 1'b0;
    wait_halt(1'b0);
    txm <= 1'b1;
    busm <= 1'b1;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("tx_act", q, 16'hC000);
    txm <= 1'b0;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("rx_act", q, 16'h4000);
    errf <= 1'b1;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("err_frame", q, 16'h0000);
    errf <= 1'b0;
    busm <= 1'b0;
    tec <= 9'd96;
    rec <= 9'd96;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("tec96", q, 16'h0000);
    rec <= 9'd97;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("rec_warn", q, 16'h0500);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h2);
    rec <= 9'd96;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("warn_back", q, 16'h0000);
    tec <= 9'd97;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("warn", q, 16'h0500);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0404, 4'h3);
    @(negedge core_clk);
    check("irq_on", {15'h0000, irq}, 16'h0001);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h1);
    @(negedge core_clk);
    check("irq_off", {15'h0000, irq}, 16'h0000);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0004, 4'h3);
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("nt_clr", q, 16'h0104);
    rmw <= 1'b1;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    rmw <= 1'b0;
    check("nt_rmw", q, 16'h0504);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0080, 4'h3);
    repeat (2) @(negedge core_clk);
    check("pin_tx", {15'h0000, pin}, 16'h0000);
    txb <= 1'b1;
    stb <= 1'b1;
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0081, 4'h3);
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("tx_defer", q, 16'h0180);
    txb <= 1'b0;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("st_defer", q, 16'h0180);
    stb <= 1'b0;
    wait_halt(1'b1);
    busm <= 1'b1;
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("halted", q & 16'h4381, 16'h0181);
    check("pin_halt", {15'h0000, pin}, 16'h0001);
    check("ben_halt", {15'h0000, ben}, 16'h0000);
    busm <= 1'b0;
    port <= 1'b0;
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    repeat (2) @(negedge core_clk);
    check("pin_port", {15'h0000, pin}, 16'h0000);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0080, 4'h3);
    port <= 1'b1;
    wait_halt(1'b0);
    tec <= 9'h100;
    wait_halt(1'b1);
    acc(1'b1, CAN_CONTROL_AND_STATUS, 16'h0080, 4'h3);
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("busoff", q, 16'h0381);
    wait_halt(1'b0);
    acc(1'b0, CAN_CONTROL_AND_STATUS, 16'h0000, 4'h3);
    check("recover", q, 16'h0480);
    check("tec_clr", {7'h00, tec}, 16'h0000);
    check("ben_run", {15'h0000, ben}, 16'h0001);
    complete_run();
  end
endmodule // ccs_control_status_tb

`default_nettype wire
